// File: rtl/sbc_host_if.sv
// sbc_host_if: host-facing logic of the system basis chip
// assumes an spi master on the far side and analog front ends that
// deliver digital levels for the bus, strap and fault events
`timescale 1ns/100ps

// Summary of operation
// RQ1: receive output reads low while the bus is dominant, high while recessive.
// RQ2: bus is driven dominant while transmit input is low, recessive when high.
// RQ3: transmit input pulls up to recessive when nothing drives it.
// RQ4: the bus transceiver works only in Normal mode.
// RQ5: serial output changes on each rising spi clock edge.
// RQ6: serial input is sampled on each falling spi clock edge.
// RQ7: serial output is released whenever chip select is high.
// RQ8: master keeps chip select low for the whole transfer.
// RQ9: chip select rising ends the transfer and latches the received command.
// RQ10: only exactly eight clocked bits make a valid transfer.
// RQ11: in Stop mode a chip select rise wakes the device.
// RQ12: in Normal Request and Normal the pulse gate input gates the switches.
// RQ13: master enables pulse gating by writing the switch control first.
// RQ14: device pulls the reset line low on its reset conditions.
// RQ15: reset line is also read as a filtered active-low input.
// RQ16: release of the reset line enters Normal Request mode; with a grounded watchdog strap the code goes straight to Normal mode.
// RQ17: interrupt goes low for events in Normal modes and on Stop wake.
// RQ18: interrupt stays low until the flags are read over spi.
// RQ19: a grounded watchdog strap disables the watchdog.
// RQ20: an open watchdog strap selects the default period of 150 ms.
// RQ21: a resistor on the watchdog strap sets the watchdog period.
// RQ22: Normal Request times out to Reset after 150 ms without a Normal command; the code only counts a Normal command that follows a timing command.
// RQ23: master waits 90 us after a chip select wake before commands.
// RQ24: master launches on rising edges and samples on falling edges.
module sbc_host_if import sbc_pkg::*; #(
	parameter int unsigned RST_HOLD_CYCLES = RST_HOLD_CYC,
	parameter int unsigned NREQ_TMO_CYCLES = NREQ_TMO_CYC,
	parameter int unsigned WD_DEF_CYCLES   = WD_DEF_CYC
) (
	// clocks and reset
	input  wire logic                core_clk_i,
	input  wire logic                resetn_i,
	input  wire logic                spi_sclk_i,
	// spi pins
	input  wire logic                spi_cs_n_i,
	input  wire logic                spi_mosi_i,
	output logic                     spi_miso_o,
	output logic                     spi_miso_oe_o,
	// single-wire bus transceiver
	input  wire logic                txd_i,
	output logic                     txd_pullup_o,
	output logic                     rxd_o,
	input  wire logic                lin_bus_i,
	output logic                     lin_dom_o,
	// reset line, open drain
	input  wire logic                rst_pin_i,
	output logic                     rst_pin_o,
	output logic                     rst_pin_oe_o,
	// interrupt
	output logic                     irq_n_o,
	// switches
	input  wire logic                pulse_gate_input_i,
	output logic                     hs_on_o,
	output logic                     ls1_on_o,
	output logic                     ls2_on_o,
	// watchdog strap and fault events
	input  wire logic [1:0]          watchdog_strap_pin_i,
	input  wire logic [TMR_W-1:0]    wd_res_period_i,
	input  wire logic [N_EVENTS-1:0] fault_event_i
);
	localparam logic [TMR_W-1:0] HOLD_LD = TMR_W'(RST_HOLD_CYCLES);
	localparam logic [TMR_W-1:0] NREQ_LD = TMR_W'(NREQ_TMO_CYCLES);
	localparam logic [TMR_W-1:0] WDEF_LD = TMR_W'(WD_DEF_CYCLES);

	typedef struct packed {
		sbc_mode_t          mode;
		logic [TMR_W-1:0]   tmr;
		logic [TMR_W-1:0]   wd_cnt;
		logic [1:0]         wd_mode;
		logic               timing_set;
		logic [3:0]         timing;
		logic [3:0]         sw;
		logic [N_FLAGS-1:0] flags;
		logic [7:0]         tx_byte;
		logic               cs_prev;
		logic               cmd_valid;
		logic [7:0]         cmd;
		logic               rst_oe;
		logic               rxd;
		logic               lin_dom;
		logic               hs_on;
		logic               ls_on;
		logic               irq_n;
	} sbc_core_t;

	sbc_core_t           st_reg;
	sbc_core_t           st_next;
	logic [5:0]          pins_s;
	logic                cs_s;
	logic                txd_s;
	logic                bus_s;
	logic                pwm_s;
	logic [1:0]          strap_s;
	logic                rst_f;
	logic [7:0]          rx_byte;
	logic [BITCNT_W-1:0] rx_count;
	logic                cs_rise;
	logic                active;
	logic [N_FLAGS-1:0]  flag_set;
	logic [N_FLAGS-1:0]  flag_clr;
	logic [TMR_W-1:0]    wd_period;

	sbc_pin_sync #(
		.WIDTH (6),
		.FILT  (NO_FILT),
		.INIT  (6'h3F)
	) u_pins (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.pin_i      ({spi_cs_n_i, txd_i, lin_bus_i, pulse_gate_input_i,
			watchdog_strap_pin_i}),
		.level_o    (pins_s)
	);

	// reset line needs a real filter; it is a slow board-level signal
	sbc_pin_sync #(
		.WIDTH (1),
		.FILT  (RST_FILT_CYC),
		.INIT  (1'b0)
	) u_rst_filt (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.pin_i      (rst_pin_i),
		.level_o    (rst_f) // RQ15
	);

	sbc_spi_link u_link (
		.spi_sclk_i    (spi_sclk_i),
		.spi_cs_n_i    (spi_cs_n_i),
		.resetn_i      (resetn_i),
		.spi_mosi_i    (spi_mosi_i),
		.spi_miso_o    (spi_miso_o),
		.spi_miso_oe_o (spi_miso_oe_o),
		.tx_byte_i     (st_reg.tx_byte),
		.rx_byte_o     (rx_byte),
		.rx_count_o    (rx_count)
	);

	assign cs_s    = pins_s[5];
	assign txd_s   = pins_s[4];
	assign bus_s   = pins_s[3];
	assign pwm_s   = pins_s[2];
	assign strap_s = pins_s[1:0];
	assign cs_rise = cs_s & ~st_reg.cs_prev;

	always_comb begin
		st_next           = st_reg;
		st_next.cs_prev   = cs_s;
		st_next.cmd_valid = 1'b0;
		active    = (st_reg.mode == M_NORMAL) || (st_reg.mode == M_NREQ);
		flag_set  = '0;
		flag_clr  = '0;
		wd_period = WDEF_LD; // RQ20
		if (st_reg.wd_mode == STRAP_RES) begin
			wd_period = wd_res_period_i; // RQ21
		end
		// rx data is stable here: the spi clock is idle once select is high
		if (cs_rise) begin
			st_next.cmd       = rx_byte; // RQ9
			st_next.cmd_valid = (rx_count == FRAME_BITS); // RQ10
		end
		if (active) begin
			flag_set[N_FLAGS-1:1] = fault_event_i; // RQ17
		end
		if (st_reg.cmd_valid && st_reg.cmd[7:5] == OP_READ_STAT) begin
			flag_clr = st_reg.tx_byte[N_FLAGS-1:0]; // RQ18
		end
		case (st_reg.mode)
			M_RESET: begin
				st_next.wd_mode    = strap_s;
				st_next.timing_set = 1'b0;
				st_next.sw         = '0;
				if (st_reg.tmr != '0) begin
					st_next.tmr    = st_reg.tmr - 24'h000001;
					st_next.rst_oe = 1'b1; // RQ14
				end else begin
					st_next.rst_oe = 1'b0;
					if (!st_reg.rst_oe && rst_f) begin
						if (st_reg.wd_mode == STRAP_GND) begin
							st_next.mode = M_NORMAL; // RQ19
						end else begin
							st_next.mode = M_NREQ; // RQ16
							st_next.tmr  = NREQ_LD;
						end
						st_next.wd_cnt = wd_period;
					end
				end
			end
			M_NREQ: begin
				if (st_reg.tmr == '0) begin
					st_next.mode   = M_RESET; // RQ22
					st_next.tmr    = HOLD_LD;
					st_next.rst_oe = 1'b1;
				end else begin
					st_next.tmr = st_reg.tmr - 24'h000001;
					if (st_reg.cmd_valid && st_reg.cmd[7:5] == OP_TIMING) begin
						st_next.timing     = st_reg.cmd[3:0];
						st_next.timing_set = 1'b1;
					end
					if (st_reg.cmd_valid && st_reg.cmd[7:5] == OP_MODE &&
						st_reg.cmd[1:0] == MODE_NORMAL && st_reg.timing_set) begin
						st_next.mode   = M_NORMAL; // RQ22
						st_next.wd_cnt = wd_period;
					end
				end
			end
			M_NORMAL: begin
				if (st_reg.wd_mode != STRAP_GND) begin
					if (st_reg.wd_cnt == '0) begin
						st_next.mode   = M_RESET;
						st_next.tmr    = HOLD_LD;
						st_next.rst_oe = 1'b1; // RQ14
					end else begin
						st_next.wd_cnt = st_reg.wd_cnt - 24'h000001;
					end
				end
				if (st_reg.cmd_valid && st_reg.cmd[7:5] == OP_WD_KICK) begin
					st_next.wd_cnt = wd_period;
				end
				if (st_reg.cmd_valid && st_reg.cmd[7:5] == OP_TIMING) begin
					st_next.timing = st_reg.cmd[3:0];
				end
				if (st_reg.cmd_valid && st_reg.cmd[7:5] == OP_MODE &&
					st_reg.cmd[1:0] == MODE_STOP) begin
					st_next.mode = M_STOP;
				end
			end
			M_STOP: begin
				if (cs_rise) begin
					st_next.mode       = M_NREQ; // RQ11
					st_next.tmr        = NREQ_LD;
					st_next.timing_set = 1'b0;
					flag_set[FLAG_WAKE] = 1'b1; // RQ17
				end
			end
			default: begin
				st_next.mode = M_RESET;
			end
		endcase
		// an outside reset pulls every mode back to Reset
		if (st_reg.mode != M_RESET && !rst_f && !st_reg.rst_oe) begin
			st_next.mode = M_RESET; // RQ15
			st_next.tmr  = '0;
		end
		// switch settings count only in the two Normal modes
		if (active && st_reg.cmd_valid && st_reg.cmd[7:5] == OP_SWITCH) begin
			st_next.sw = st_reg.cmd[3:0]; // RQ13
		end
		// a new event beats a clear in the same cycle
		st_next.flags = (st_reg.flags & ~flag_clr) | flag_set;
		st_next.irq_n = ~|st_next.flags; // RQ18
		// status snapshot frozen from select fall until the read is acted on
		if (cs_s && st_reg.cs_prev && !st_reg.cmd_valid) begin
			st_next.tx_byte = {2'(st_reg.mode), 2'h0, st_reg.flags};
		end
		st_next.lin_dom = (st_reg.mode == M_NORMAL) && !txd_s; // RQ2 RQ4
		st_next.rxd     = (st_reg.mode == M_NORMAL) ? bus_s : 1'b1; // RQ1 RQ4
		st_next.hs_on   = active && st_reg.sw[SW_HS_ON] &&
			(!st_reg.sw[SW_HS_PWM] || pwm_s); // RQ12
		st_next.ls_on   = active && st_reg.sw[SW_LS_ON] &&
			(!st_reg.sw[SW_LS_PWM] || pwm_s); // RQ12
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg        <= '0;
			st_reg.mode   <= M_RESET;
			st_reg.tmr    <= HOLD_LD;
			st_reg.rst_oe <= 1'b1;
			st_reg.rxd    <= 1'b1;
			st_reg.irq_n  <= 1'b1;
			st_reg.cs_prev <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// the weak pull-up keeps a floating transmit input recessive
	assign txd_pullup_o = resetn_i | 1'b1; // RQ3
	assign rst_pin_o    = 1'b0;
	assign rst_pin_oe_o = st_reg.rst_oe;
	assign rxd_o        = st_reg.rxd;
	assign lin_dom_o    = st_reg.lin_dom;
	assign irq_n_o      = st_reg.irq_n;
	assign hs_on_o      = st_reg.hs_on;
	assign ls1_on_o     = st_reg.ls_on;
	assign ls2_on_o     = st_reg.ls_on;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence stop_cs_rise;
		st_reg.mode == M_STOP && cs_rise && rst_f;
	endsequence

	sequence woke_up;
		st_reg.mode == M_NREQ && st_reg.flags[FLAG_WAKE] ##1 !irq_n_o;
	endsequence

	rxd_follow_a: assert property ( // RQ1
		st_reg.mode == M_NORMAL |=> rxd_o == $past(bus_s))
		else $error("receive output does not follow the bus");
	lin_dom_a: assert property ( // RQ2
		lin_dom_o |-> $past(st_reg.mode) == M_NORMAL && !$past(txd_s))
		else $error("bus driven dominant without cause");
	miso_hiz_a: assert property ( // RQ7
		cs_s && st_reg.cs_prev && $past(cs_s, 2) |-> !spi_miso_oe_o)
		else $error("serial output driven while deselected");
	frame_len_a: assert property ( // RQ10
		cs_rise |=> st_reg.cmd_valid == ($past(rx_count) == FRAME_BITS))
		else $error("frame validity does not match bit count");
	stop_wake_a: assert property ( // RQ11
		stop_cs_rise |=> woke_up)
		else $error("no wake-up after select rise in stop mode");
	pwm_gate_a: assert property ( // RQ12
		st_reg.mode == M_NORMAL && st_reg.sw[SW_HS_ON] &&
		st_reg.sw[SW_HS_PWM] && !pwm_s |=> !hs_on_o)
		else $error("high side on while pulse gate is low");
	rst_drive_a: assert property ( // RQ14
		st_reg.mode == M_RESET && st_reg.tmr != '0 |=> rst_pin_oe_o)
		else $error("reset line not pulled during reset hold");
	irq_hold_a: assert property ( // RQ18
		!irq_n_o && !(st_reg.cmd_valid && st_reg.cmd[7:5] == OP_READ_STAT)
		|=> !irq_n_o)
		else $error("interrupt released without a status read");
	rst_release_a: assert property ( // RQ16
		st_reg.mode == M_RESET && st_reg.tmr == '0 && !st_reg.rst_oe &&
		rst_f && st_reg.wd_mode != STRAP_GND
		|=> st_reg.mode == M_NREQ && st_reg.tmr == NREQ_LD)
		else $error("reset release did not enter normal request");
	wd_off_a: assert property ( // RQ19
		st_reg.mode == M_RESET && st_reg.tmr == '0 && !st_reg.rst_oe &&
		rst_f && st_reg.wd_mode == STRAP_GND |=> st_reg.mode == M_NORMAL)
		else $error("grounded strap did not skip normal request");
	nreq_tmo_a: assert property ( // RQ22
		st_reg.mode == M_NREQ && st_reg.tmr == '0 && rst_f
		|=> st_reg.mode == M_RESET && rst_pin_oe_o [*2])
		else $error("normal request timeout did not reset");
endmodule // sbc_host_if

// File: rtl/sbc_pkg.sv
// sbc_pkg: shared constants and types of the host-side interface block
// assumes a 40 MHz core clock; the spi clock is a separate domain
package sbc_pkg;
	// timing
	localparam int unsigned CORE_CLK_KHZ = 40_000;
	localparam int unsigned RST_HOLD_US  = 1000;
	localparam int unsigned NREQ_TMO_MS  = 150;
	localparam int unsigned WD_DEF_MS    = 150;
	localparam int unsigned RST_HOLD_CYC = RST_HOLD_US * CORE_CLK_KHZ / 1000;
	localparam int unsigned NREQ_TMO_CYC = NREQ_TMO_MS * CORE_CLK_KHZ;
	localparam int unsigned WD_DEF_CYC   = WD_DEF_MS * CORE_CLK_KHZ;
	localparam int unsigned TMR_W        = 24;
	localparam int unsigned FILT_W       = 4;
	localparam logic [FILT_W-1:0] RST_FILT_CYC = 4'h8;
	localparam logic [FILT_W-1:0] NO_FILT      = 4'h1;
	// serial frame
	localparam int unsigned BITCNT_W = 4;
	localparam logic [BITCNT_W-1:0] FRAME_BITS = 4'h8;
	localparam logic [BITCNT_W-1:0] CNT_SAT    = 4'h9;
	// command byte: opcode in [7:5], argument in [3:0]
	localparam logic [2:0] OP_READ_STAT = 3'h0;
	localparam logic [2:0] OP_MODE      = 3'h1;
	localparam logic [2:0] OP_TIMING    = 3'h2;
	localparam logic [2:0] OP_SWITCH    = 3'h3;
	localparam logic [2:0] OP_WD_KICK   = 3'h4;
	localparam logic [1:0] MODE_NORMAL  = 2'h0;
	localparam logic [1:0] MODE_STOP    = 2'h1;
	// switch argument bits
	localparam int unsigned SW_HS_ON  = 0;
	localparam int unsigned SW_HS_PWM = 1;
	localparam int unsigned SW_LS_ON  = 2;
	localparam int unsigned SW_LS_PWM = 3;
	// status flags: wake in bit 0, fault events above
	localparam int unsigned N_EVENTS  = 3;
	localparam int unsigned N_FLAGS   = 4;
	localparam int unsigned FLAG_WAKE = 0;
	// watchdog strap codes
	localparam logic [1:0] STRAP_GND  = 2'h0;
	localparam logic [1:0] STRAP_RES  = 2'h1;
	localparam logic [1:0] STRAP_OPEN = 2'h3;

	typedef enum logic [1:0] {M_RESET, M_NREQ, M_NORMAL, M_STOP} sbc_mode_t;

	typedef struct packed {
		logic              s1;
		logic              s2;
		logic              val;
		logic [FILT_W-1:0] cnt;
	} sbc_filt_t;

	typedef struct packed {
		logic [7:0]          shift;
		logic [BITCNT_W-1:0] cnt;
	} sbc_rx_t;

	typedef struct packed {
		logic [BITCNT_W-1:0] idx;
		logic                miso;
		logic                oe;
	} sbc_tx_t;
endpackage

// File: rtl/sbc_pin_sync.sv
// sbc_pin_sync: two-flop synchroniser plus stability filter per pin
// assumes pins are asynchronous to core_clk_i
`timescale 1ns/100ps
module sbc_pin_sync import sbc_pkg::*; #(
	parameter int unsigned       WIDTH = 1,
	parameter logic [FILT_W-1:0] FILT  = 4'h1,
	parameter logic [WIDTH-1:0]  INIT  = '0
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             resetn_i,
	// pins and filtered levels
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o
);
	genvar g;
	for (g = 0; g < WIDTH; g++) begin : g_bit
		sbc_filt_t st_reg;
		sbc_filt_t st_next;
		always_comb begin
			st_next    = st_reg;
			st_next.s1 = pin_i[g];
			st_next.s2 = st_reg.s1;
			// a new level is taken only after FILT stable samples
			if (st_reg.s2 == st_reg.val) begin
				st_next.cnt = '0;
			end else if (st_reg.cnt >= FILT - 4'h1) begin
				st_next.val = st_reg.s2;
				st_next.cnt = '0;
			end else begin
				st_next.cnt = st_reg.cnt + 4'h1;
			end
		end
		always_ff @(posedge core_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				st_reg <= '{s1: INIT[g], s2: INIT[g], val: INIT[g], cnt: '0};
			end else begin
				st_reg <= st_next;
			end
		end
		assign level_o[g] = st_reg.val;
	end
endmodule // sbc_pin_sync

// File: rtl/sbc_spi_link.sv
// sbc_spi_link: spi shifter running on the spi clock itself
// assumes clock idles low, master holds chip select low through a frame
`timescale 1ns/100ps
module sbc_spi_link import sbc_pkg::*; (
	// link clock and resets
	input  wire logic                spi_sclk_i,
	input  wire logic                spi_cs_n_i,
	input  wire logic                resetn_i,
	// serial pins
	input  wire logic                spi_mosi_i,
	output logic                     spi_miso_o,
	output logic                     spi_miso_oe_o,
	// core side: tx byte quasi-static while chip select is low, rx outputs while it is high
	input  wire logic [7:0]          tx_byte_i,
	output logic      [7:0]          rx_byte_o,
	output logic      [BITCNT_W-1:0] rx_count_o
);
	logic    fresh_reg;
	logic    tx_clr;
	sbc_rx_t rx_reg;
	sbc_rx_t rx_next;
	sbc_tx_t tx_reg;
	sbc_tx_t tx_next;
	logic    start_tgl_reg;
	logic    seen_tgl_reg;

	assign tx_clr = spi_cs_n_i | ~resetn_i;

	// a select pulse with no clock must not replay the previous frame
	always_ff @(negedge spi_cs_n_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start_tgl_reg <= 1'b0;
		end else begin
			start_tgl_reg <= ~start_tgl_reg;
		end
	end

	// start toggle is quasi-static here: select falls well before the clock
	always_ff @(negedge spi_sclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			seen_tgl_reg <= 1'b0;
		end else begin
			seen_tgl_reg <= start_tgl_reg;
		end
	end

	// marks the first falling edge of a frame; the clock stops between frames
	always_ff @(negedge spi_sclk_i or posedge spi_cs_n_i) begin
		if (spi_cs_n_i) begin
			fresh_reg <= 1'b1;
		end else begin
			fresh_reg <= 1'b0;
		end
	end

	always_comb begin
		rx_next = rx_reg;
		if (fresh_reg) begin
			rx_next.shift = {7'h00, spi_mosi_i};
			rx_next.cnt   = 4'h1;
		end else begin
			rx_next.shift = {rx_reg.shift[6:0], spi_mosi_i};
			if (rx_reg.cnt != CNT_SAT) begin
				rx_next.cnt = rx_reg.cnt + 4'h1;
			end
		end
	end

	// data in is sampled on the falling edge
	always_ff @(negedge spi_sclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_reg <= '0;
		end else begin
			rx_reg <= rx_next; // RQ6
		end
	end

	always_comb begin
		tx_next    = tx_reg;
		tx_next.oe = 1'b1;
		if (tx_reg.idx < FRAME_BITS) begin
			tx_next.miso = tx_byte_i[~tx_reg.idx[2:0]];
			tx_next.idx  = tx_reg.idx + 4'h1;
		end else begin
			tx_next.miso = 1'b0;
		end
	end

	// data out changes on the rising edge, released while deselected
	always_ff @(posedge spi_sclk_i or posedge tx_clr) begin
		if (tx_clr) begin
			tx_reg <= '0; // RQ7
		end else begin
			tx_reg <= tx_next; // RQ5
		end
	end

	assign spi_miso_o    = tx_reg.miso;
	assign spi_miso_oe_o = tx_reg.oe;
	assign rx_byte_o     = rx_reg.shift;
	assign rx_count_o    = (seen_tgl_reg == start_tgl_reg) ? rx_reg.cnt : '0; // RQ10
endmodule // sbc_spi_link

// File: tb/sbc_mcu_model.sv
// sbc_mcu_model: spi master side of the host microcontroller
// assumes the device changes miso after rising edges of an idle-low clock
`timescale 1ns/100ps
module sbc_mcu_model (
	// spi pins
	output logic      spi_sclk_o,
	output logic      spi_cs_n_o,
	output logic      spi_mosi_o,
	input  wire logic spi_miso_i
);
	localparam int HALF = 32;
	initial begin
		spi_sclk_o = 1'b0;
		spi_cs_n_o = 1'b1;
		spi_mosi_o = 1'b0;
	end
	// sends the low n bits of v msb first; clock stands still between frames
	task automatic xfer(input logic [15:0] v, input int n,
		output logic [7:0] r);
		r = 8'h00;
		#7;
		spi_cs_n_o = 1'b0;
		#100;
		for (int i = n - 1; i >= 0; i--) begin
			spi_sclk_o = 1'b1;
			#2 spi_mosi_o = v[i];
			#(HALF - 2) spi_sclk_o = 1'b0;
			r = {r[6:0], spi_miso_i};
			#HALF;
		end
		spi_cs_n_o = 1'b1;
		// a released line must not keep showing the last bit
		spi_mosi_o = ~spi_mosi_o;
		#250;
	endtask
endmodule // sbc_mcu_model

// File: tb/test_sbc_host_if.sv
// test_sbc_host_if: scenario bench for the host-side interface block
// assumes sbc_mcu_model as spi master; open-drain lines resolved here
`timescale 1ns/100ps
module test_sbc_host_if import sbc_pkg::*; ;
	localparam int HOLD   = 20;
	localparam int NREQ_T = 8000;
	localparam int WD_T   = 300;
	localparam int WD_R   = 100;
	localparam int LIMIT  = 30000;
	logic core_clk_i, resetn_i, sclk, cs_n, mosi, miso, miso_oe, miso_w;
	logic txd, txd_pu, rxd, lin_bus, lin_dom, peer_dom;
	logic rst_line, rst_o, rst_oe, mcu_rst, irq_n, gate, hs, ls1, ls2;
	logic [1:0]          strap;
	logic [TMR_W-1:0]    wd_per;
	logic [N_EVENTS-1:0] fault;
	logic [7:0]          rep;
	int fails = 0, check_count = 0, cyc = 0, n = 0;

	assign miso_w = miso_oe ? miso : 1'bz;
	assign lin_bus = ~(lin_dom | peer_dom);
	assign rst_line = ((rst_oe & ~rst_o) | mcu_rst) ? 1'b0 : 1'b1;

	sbc_host_if #(.RST_HOLD_CYCLES(HOLD), .NREQ_TMO_CYCLES(NREQ_T),
		.WD_DEF_CYCLES(WD_T)) DUT (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk),
		.spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
		.spi_miso_oe_o(miso_oe), .txd_i(txd), .txd_pullup_o(txd_pu),
		.rxd_o(rxd), .lin_bus_i(lin_bus), .lin_dom_o(lin_dom),
		.rst_pin_i(rst_line), .rst_pin_o(rst_o), .rst_pin_oe_o(rst_oe),
		.irq_n_o(irq_n), .pulse_gate_input_i(gate), .hs_on_o(hs),
		.ls1_on_o(ls1), .ls2_on_o(ls2), .watchdog_strap_pin_i(strap),
		.wd_res_period_i(wd_per), .fault_event_i(fault));
	sbc_mcu_model mcu (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
		.spi_mosi_o(mosi), .spi_miso_i(miso_w));

	task automatic chk(input string what, input logic [15:0] e, g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %0h seen %0h", what, e, g);
		end
	endtask
	task automatic rng(input string what, input int lo, hi, v);
		check_count++;
		if (v < lo || v > hi) begin
			fails++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, v);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge core_clk_i);
	endtask
	task automatic cmd(input logic [7:0] c);
		mcu.xfer({8'h00, c}, 8, rep);
		tick(1);
	endtask
	// counts core cycles until the device's reset pull reaches v
	task automatic till_oe(input logic v, input int lim);
		n = 0;
		while (rst_oe !== v && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	task automatic start(input logic [1:0] s);
		tick(1);
		strap = s;
		resetn_i = 1'b0;
		tick(12);
		chk("rst_oe", 1, rst_oe);
		chk("irq_n", 1, irq_n);
		resetn_i = 1'b1;
		till_oe(1'b0, 100);
		rng("hold", HOLD - 1, HOLD + 2, n);
		tick(20);
	endtask
	// watchdog held off by a huge resistor period; mode and timeout checks
	task automatic t_nreq;
		start(STRAP_RES);
		cmd(8'h00);
		chk("mode", 2'h1, rep[7:6]);
		txd = 1'b0;
		peer_dom = 1'b1;
		tick(6);
		chk("lin_dom", 0, lin_dom);
		chk("rxd", 1, rxd);
		txd = 1'b1;
		peer_dom = 1'b0;
		cmd(8'h40);
		cmd(8'h20);
		cmd(8'h00);
		chk("mode", 2'h2, rep[7:6]);
		mcu_rst = 1'b1;
		tick(30);
		mcu_rst = 1'b0;
		tick(40);
		till_oe(1'b0, 100);
		tick(20);
		cmd(8'h00);
		chk("mode", 2'h1, rep[7:6]);
		till_oe(1'b1, NREQ_T + 10);
		rng("timeout", NREQ_T - 300, NREQ_T, n);
	endtask
	task automatic t_wd(input logic [1:0] s, input int per);
		start(s);
		cmd(8'h40);
		cmd(8'h20);
		cmd(8'h80);
		till_oe(1'b1, per + 50);
		rng("wd", per - 15, per, n);
	endtask
	task automatic t_gnd;
		start(STRAP_GND);
		cmd(8'h00);
		chk("mode", 2'h2, rep[7:6]);
		till_oe(1'b1, 2 * WD_T);
		chk("wd off", 2 * WD_T, n);
	endtask
	task automatic t_lin;
		chk("txd_pu", 1, txd_pu);
		txd = 1'b0;
		// transmit sync, bus drive, bus sync and receive flop: 8 cycles
		tick(10);
		chk("lin_dom", 1, lin_dom);
		chk("rxd", 0, rxd);
		txd = 1'b1;
		tick(10);
		chk("lin_dom", 0, lin_dom);
		chk("rxd", 1, rxd);
		peer_dom = 1'b1;
		tick(6);
		chk("rxd", 0, rxd);
		peer_dom = 1'b0;
	endtask
	// a stop command cut short or overlong must leave the mode alone
	task automatic t_count;
		mcu.xfer(16'h0021, 7, rep);
		mcu.xfer(16'h0021, 9, rep);
		tick(1);
		chk("miso_oe", 0, miso_oe);
		cmd(8'h00);
		chk("mode", 2'h2, rep[7:6]);
	endtask
	task automatic t_sw;
		cmd(8'h6F);
		gate = 1'b1;
		tick(6);
		chk("sw", 3'h7, {hs, ls1, ls2});
		gate = 1'b0;
		tick(6);
		chk("sw", 3'h0, {hs, ls1, ls2});
		cmd(8'h61);
		chk("sw", 3'h4, {hs, ls1, ls2});
		cmd(8'h60);
	endtask
	task automatic t_irq;
		fault = 3'h2;
		tick(1);
		fault = 3'h0;
		tick(40);
		chk("irq_n", 0, irq_n);
		cmd(8'h00);
		chk("reply", 8'h84, rep);
		chk("irq_n", 1, irq_n);
	endtask
	task automatic t_stop;
		cmd(8'h21);
		cmd(8'h00);
		chk("reply", 8'hC0, rep);
		chk("irq_n", 0, irq_n);
		tick(3600);
		cmd(8'h00);
		chk("reply", 8'h41, rep);
		chk("irq_n", 1, irq_n);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		resetn_i = 1'b0;
		txd = 1'b1;
		peer_dom = 1'b0;
		mcu_rst = 1'b0;
		gate = 1'b0;
		strap = STRAP_OPEN;
		fault = 3'h0;
		wd_per = 24'hFFFFFF;
		t_nreq();
		wd_per = 24'h000064;
		t_wd(STRAP_RES, WD_R);
		t_wd(STRAP_OPEN, WD_T);
		t_gnd();
		t_lin();
		t_count();
		t_sw();
		t_irq();
		t_stop();
		print_verdict();
	end
endmodule // test_sbc_host_if
